// ---- spi_link_regs.svh ----
// Shared timing counts, codes and pin indices for both ends of the serial link
`ifndef SPI_LINK_REGS_SVH
`define SPI_LINK_REGS_SVH

// Core clock period
`define CLK_PERIOD_NS      10
// Character length and last bit index
`define CHAR_BITS          8
`define BIT_LAST           3'h7
// Memory clock half period driven by the receiver as master (least time, rounded up)
`define DEV_HALF_NS        80
`define DEV_HALF_CYC       ((`DEV_HALF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Link clock half period driven by the host (least time, rounded up)
`define HOST_HALF_NS       200
`define HOST_HALF_CYC      ((`HOST_HALF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Start-up strap sampling window in the receiver
`define CFG_WINDOW_NS      400
`define CFG_WINDOW_CYC     ((`CFG_WINDOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Host keeps the select high at least this long after reset
`define HOST_STARTUP_NS    1500
`define HOST_STARTUP_CYC   ((`HOST_STARTUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Memory probe: identify command, dummy byte and accepted size code (arbitrary value)
`define MEM_PROBE_CMD      8'h9f
`define MEM_DUMMY          8'hff
`define MEM_SIZE_CODE      8'h11
// Bit positions in the receiver's link input synchroniser
`define PIN_SCK            0
`define PIN_SEL            1
`define PIN_MOSI           2
`define PIN_CNT            3

`endif

// ---- spi_link_pkg.sv ----
// Types for the receiver end and the host end of the serial link
package spi_link_pkg;
`include "spi_link_regs.svh"

  // Receiver life phases
  typedef enum logic [1:0] {PH_CFG, PH_PROBE_CMD, PH_PROBE_ID, PH_RUN} dev_phase_t;
  // Byte engine states, shared shape for both masters
  typedef enum logic [1:0] {E_IDLE, E_LOW, E_HIGH, E_GAP} eng_state_t;

  // Whole receiver state
  typedef struct packed {
    logic [`PIN_CNT-1:0]   s1;         // Link pin sync stage 1
    logic [`PIN_CNT-1:0]   s2;         // Link pin sync stage 2
    logic [`PIN_CNT-1:0]   s3;         // Link pin sync stage 3
    logic [`PIN_CNT-1:0]   f;          // Agreed link pin levels
    logic                  m1;         // Memory data sync stages
    logic                  m2;
    logic                  m3;
    logic                  mf;
    dev_phase_t            phase;
    logic                  run;        // Start-up over; flop behind the done output
    logic [7:0]            wait_cnt;   // Strap window counter
    logic [1:0]            cfg;        // Frozen start-up straps
    logic [`CHAR_BITS-1:0] sl_sh;      // Slave shift register
    logic [2:0]            sl_cnt;     // Slave bit counter
    logic                  miso;
    logic                  miso_oe;
    logic [`CHAR_BITS-1:0] rx;
    logic                  rx_stb;
    eng_state_t            me;         // Memory engine
    logic [7:0]            mdiv;
    logic [2:0]            mcnt;
    logic [`CHAR_BITS-1:0] msh;
    logic                  msck;
    logic                  mmosi;
    logic                  msel_n;
    logic                  ssel_n;
    logic                  mlast;
    logic                  present;
    logic                  ready;
    logic [`CHAR_BITS-1:0] mrx;
    logic                  mdone;
  } dev_state_t;

  // Whole host state
  typedef struct packed {
    logic                  s1;         // Returned data sync stages
    logic                  s2;
    logic                  s3;
    logic                  f;
    logic                  started;
    eng_state_t            st;
    logic [7:0]            cnt;
    logic [2:0]            bcnt;
    logic [`CHAR_BITS-1:0] sh;
    logic                  sck;
    logic                  mosi;
    logic                  ss_n;
    logic                  last;
    logic                  ready;
    logic [`CHAR_BITS-1:0] rx;
    logic                  done;
  } host_state_t;
endpackage

// ---- spi_link_if.sv ----
// Four-wire link between the host and the receiver
`timescale 1ns/1ns
interface spi_link_if;
  logic sck;        // Serial clock from the host
  logic ss_n;       // Receiver select, active low
  logic mosi;       // Host to receiver data
  logic miso_drv;   // Receiver data as driven
  logic miso_oe;    // Receiver drives the return line
  logic miso_line;  // Resolved return line

  // Undriven return line floats up through the pull-up
  assign miso_line = miso_oe ? miso_drv : 1'h1;

  modport dev_end  (input sck, ss_n, mosi, output miso_drv, miso_oe);
  modport host_end (output sck, ss_n, mosi, input miso_line);
endinterface

// ---- receiver_spi_port.sv ----
// Receiver end: link slave, start-up straps and serial memory master
`timescale 1ns/1ns

module receiver_spi_port
  import spi_link_pkg::*;
(
  // Clock and reset
  input  wire logic                  core_clk_in,
  input  wire logic                  sys_rst_in,
  // Link to the host
  spi_link_if.dev_end                link,
  // Slave user side
  input  wire logic [`CHAR_BITS-1:0] tx_byte_in,
  output logic      [`CHAR_BITS-1:0] rx_byte_out,
  output logic                       rx_valid_out,
  // Start-up results
  output logic      [1:0]            cfg_out,
  output logic                       startup_done_out,
  output logic                       mem_present_out,
  // Memory user side
  input  wire logic                  mem_req_in,
  input  wire logic [`CHAR_BITS-1:0] mem_tx_in,
  input  wire logic                  mem_last_in,
  input  wire logic                  second_sel_in,
  output logic                       mem_ready_out,
  output logic      [`CHAR_BITS-1:0] mem_rx_out,
  output logic                       mem_done_out,
  // Memory pins
  output logic                       mem_sck_out,
  output logic                       mem_mosi_out,
  input  wire logic                  mem_miso_in,
  output logic                       memory_select_n,
  output logic                       second_select_n
);

  dev_state_t q;   // Registered state
  dev_state_t d;   // Next state

  // Next-state logic for the whole port
  always_comb
  begin : next_state
    logic                  rise;     // Agreed link clock rising
    logic                  fall;     // Agreed link clock falling
    logic                  eng_done; // Memory byte finished this cycle
    logic                  go;       // Start the memory engine
    logic [`CHAR_BITS-1:0] go_byte;  // Byte the engine starts with
    rise     = 1'h0;
    fall     = 1'h0;
    eng_done = 1'h0;
    go       = 1'h0;
    go_byte  = `MEM_DUMMY;
    d        = q;
    d.rx_stb = 1'h0;
    d.mdone  = 1'h0;

    // Three-stage sync; a level counts once stages two and three agree
    d.s1 = {link.mosi, link.ss_n, link.sck};
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.f  = (q.s2 & q.s3) | (q.f & (q.s2 | q.s3));
    d.m1 = mem_miso_in;
    d.m2 = q.m1;
    d.m3 = q.m2;
    d.mf = (q.m2 & q.m3) | (q.mf & (q.m2 | q.m3));
    rise = d.f[`PIN_SCK] & ~q.f[`PIN_SCK];
    fall = ~d.f[`PIN_SCK] & q.f[`PIN_SCK];

    // Memory byte engine
    // divided memory clock
    case (q.me)
      E_LOW:
      begin
        d.mdiv = q.mdiv + 8'h1;
        if (q.mdiv == 8'(`DEV_HALF_CYC - 1))
        begin
          d.mdiv = 8'h0;
          d.msck = 1'h1;
          d.msh  = {q.msh[`CHAR_BITS-2:0], q.mf};
          d.me   = E_HIGH;
        end
      end
      E_HIGH:
      begin
        d.mdiv = q.mdiv + 8'h1;
        if (q.mdiv == 8'(`DEV_HALF_CYC - 1))
        begin
          d.mdiv = 8'h0;
          d.msck = 1'h0;
          if (q.mcnt == `BIT_LAST)
          begin
            d.me     = E_IDLE;
            eng_done = 1'h1;
          end
          else
          begin
            d.mcnt  = q.mcnt + 3'h1;
            d.mmosi = q.msh[`CHAR_BITS-1];
            d.me    = E_LOW;
          end
        end
      end
      default:
      begin
        // Idle: clock rests low
        d.msck = 1'h0;
      end
    endcase

    // Phase sequencing
    case (q.phase)
      PH_CFG:
      begin
        // select is high here, so clock and data are straps
        d.wait_cnt = q.wait_cnt + 8'h1;
        if (q.wait_cnt == 8'(`CFG_WINDOW_CYC - 1))
        begin
          d.cfg    = {q.f[`PIN_MOSI], q.f[`PIN_SCK]};
          // probe the memory on the first select
          d.msel_n = 1'h0;
          go       = 1'h1;
          go_byte  = `MEM_PROBE_CMD;
          d.phase  = PH_PROBE_CMD;
        end
      end
      PH_PROBE_CMD:
      begin
        if (eng_done)
        begin
          go      = 1'h1;
          d.phase = PH_PROBE_ID;
        end
      end
      PH_PROBE_ID:
      begin
        if (eng_done)
        begin
          d.msel_n  = 1'h1;
          d.present = (d.msh == `MEM_SIZE_CODE);
          d.phase   = PH_RUN;
          d.run     = 1'h1;
        end
      end
      default:
      begin
        // Straps stay as caught; pins now serve the link only
        // configuration frozen
        d.cfg = q.cfg;
        // Slave link
        if (d.f[`PIN_SEL])
        begin
          d.miso_oe = 1'h0;
          d.sl_cnt  = 3'h0;
        end
        else if (q.f[`PIN_SEL])
        begin
          // first bit valid before the first rising edge
          d.sl_sh   = tx_byte_in;
          d.miso    = tx_byte_in[`CHAR_BITS-1];
          d.miso_oe = 1'h1;
          d.sl_cnt  = 3'h0;
        end
        else if (rise)
        begin
          // host data in on the rising edge
          d.sl_sh  = {q.sl_sh[`CHAR_BITS-2:0], q.f[`PIN_MOSI]};
          d.sl_cnt = q.sl_cnt + 3'h1;
          if (q.sl_cnt == `BIT_LAST)
          begin
            d.rx     = d.sl_sh;
            d.rx_stb = 1'h1;
          end
        end
        else if (fall)
        begin
          // own data out on the falling edge
          if (q.sl_cnt == 3'h0)
          begin
            d.sl_sh = tx_byte_in;
            d.miso  = tx_byte_in[`CHAR_BITS-1];
          end
          else
          begin
            d.miso = q.sl_sh[`CHAR_BITS-1];
          end
        end

        // Memory requests, only with a supported memory present
        if (eng_done)
        begin
          d.mrx   = d.msh;
          d.mdone = 1'h1;
          if (q.mlast)
          begin
            d.msel_n = 1'h1;
          end
        end
        else if (mem_req_in && q.ready)
        begin
          d.msel_n = 1'h0;
          d.mlast  = mem_last_in;
          go       = 1'h1;
          go_byte  = mem_tx_in;
        end
      end
    endcase

    // Engine start; most significant bit presented at once
    if (go)
    begin
      d.me    = E_LOW;
      d.mdiv  = 8'h0;
      d.mcnt  = 3'h0;
      d.msh   = go_byte;
      d.mmosi = go_byte[`CHAR_BITS-1];
      d.msck  = 1'h0;
    end

    // spare select follows its user input
    d.ssel_n = ~second_sel_in;
    d.ready  = (d.phase == PH_RUN) && (d.me == E_IDLE) && d.present && !go;

    // Synchronous reset to constants
    if (sys_rst_in)
    begin
      d        = '0;
      d.phase  = PH_CFG;
      d.me     = E_IDLE;
      d.f      = '1;
      d.msel_n = 1'h1;
      d.ssel_n = 1'h1;
    end
  end

  // Single state register
  always_ff @(posedge core_clk_in)
  begin
    q <= d;
  end

  // Outputs straight from the state register
  // the return line carries only this port's own data
  assign link.miso_drv    = q.miso;
  assign link.miso_oe     = q.miso_oe;
  assign rx_byte_out      = q.rx;
  assign rx_valid_out     = q.rx_stb;
  assign cfg_out          = q.cfg;
  assign startup_done_out = q.run;
  assign mem_present_out  = q.present;
  assign mem_ready_out    = q.ready;
  assign mem_rx_out       = q.mrx;
  assign mem_done_out     = q.mdone;
  assign mem_sck_out      = q.msck;
  assign mem_mosi_out     = q.mmosi;
  assign memory_select_n  = q.msel_n;
  assign second_select_n  = q.ssel_n;

endmodule

// ---- spi_host_end.sv ----
// Host end: link master driving clock, select and data
`timescale 1ns/1ns
module spi_host_end
  import spi_link_pkg::*;
(
  // Clock and reset
  input  wire logic                  core_clk_in,
  input  wire logic                  sys_rst_in,
  // Link to the receiver
  spi_link_if.host_end               link,
  // Start-up straps
  input  wire logic [1:0]            strap_in,
  // User side
  input  wire logic                  xfer_req_in,
  input  wire logic [`CHAR_BITS-1:0] tx_byte_in,
  input  wire logic                  last_in,
  output logic                       ready_out,
  output logic      [`CHAR_BITS-1:0] rx_byte_out,
  output logic                       done_out
);

  host_state_t q;   // Registered state
  host_state_t d;   // Next state

  // Next-state logic for the master
  always_comb
  begin
    d      = q;
    d.done = 1'h0;
    // Three-stage sync of the returned data
    d.s1 = link.miso_line;
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.f  = (q.s2 & q.s3) | (q.f & (q.s2 | q.s3));

    if (!q.started)
    begin
      // select held high while straps are on clock and data
      d.ss_n = 1'h1;
      d.sck  = strap_in[0];
      d.mosi = strap_in[1];
      d.cnt  = q.cnt + 8'h1;
      if (q.cnt == 8'(`HOST_STARTUP_CYC - 1))
      begin
        d.started = 1'h1;
        d.sck     = 1'h0;
        d.mosi    = 1'h0;
        d.cnt     = 8'h0;
      end
    end
    else
    begin
      case (q.st)
        E_IDLE:
        begin
          if (xfer_req_in)
          begin
            // host selects and clocks; first bit out now
            d.ss_n = 1'h0;
            d.sh   = tx_byte_in;
            d.mosi = tx_byte_in[`CHAR_BITS-1];
            d.last = last_in;
            d.cnt  = 8'h0;
            d.bcnt = 3'h0;
            d.st   = E_LOW;
          end
        end
        E_LOW:
        begin
          d.cnt = q.cnt + 8'h1;
          if (q.cnt == 8'(`HOST_HALF_CYC - 1))
          begin
            d.cnt = 8'h0;
            d.sck = 1'h1;
            d.sh  = {q.sh[`CHAR_BITS-2:0], q.f};
            d.st  = E_HIGH;
          end
        end
        E_HIGH:
        begin
          d.cnt = q.cnt + 8'h1;
          if (q.cnt == 8'(`HOST_HALF_CYC - 1))
          begin
            d.cnt = 8'h0;
            d.sck = 1'h0;
            if (q.bcnt == `BIT_LAST)
            begin
              d.rx   = q.sh;
              d.done = 1'h1;
              d.ss_n = q.last;
              d.st   = q.last ? E_GAP : E_IDLE;
            end
            else
            begin
              d.bcnt = q.bcnt + 3'h1;
              d.mosi = q.sh[`CHAR_BITS-1];
              d.st   = E_LOW;
            end
          end
        end
        default:
        begin
          // Select stays high long enough for the receiver to see it
          d.cnt = q.cnt + 8'h1;
          if (q.cnt == 8'(`HOST_HALF_CYC - 1))
          begin
            d.cnt = 8'h0;
            d.st  = E_IDLE;
          end
        end
      endcase
    end
    d.ready = d.started && (d.st == E_IDLE) && !(q.st == E_IDLE && xfer_req_in && q.started);

    // Synchronous reset to constants
    if (sys_rst_in)
    begin
      d      = '0;
      d.st   = E_IDLE;
      d.ss_n = 1'h1;
      d.f    = 1'h1;
    end
  end

  // Single state register
  always_ff @(posedge core_clk_in)
  begin
    q <= d;
  end

  // Outputs straight from the state register
  assign link.sck    = q.sck;
  assign link.ss_n   = q.ss_n;
  assign link.mosi   = q.mosi;
  assign ready_out   = q.ready;
  assign rx_byte_out = q.rx;
  assign done_out    = q.done;

endmodule

// ---- receiver_spi_port_assertions.sv ----
// Checker for the wires between the host end and the receiver end
`timescale 1ns/1ns
`include "spi_link_regs.svh"
module receiver_spi_port_assertions (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  // Link wires
  input wire logic sck,
  input wire logic ss_n,
  input wire logic mosi,
  input wire logic miso_drv,
  input wire logic miso_oe,
  input wire logic miso_line
);
  localparam int HOLD_CYC  = `HOST_STARTUP_CYC;  // Host select hold
  localparam int HALF_CYC  = `HOST_HALF_CYC;     // Host clock half period
  localparam int READY_CYC = 400;                // Probe over; traffic checks start
  // Helper state, one struct
  typedef struct packed {
    logic [8:0] up_cnt;  // Cycles since reset, saturating
    logic       sck;     // Clock one cycle ago
    logic [2:0] bits;    // Rises under select, modulo a byte
  } chk_state_t;
  chk_state_t state_q;   // Registered state
  chk_state_t state_d;   // Next state
  logic       ready;     // Both ends past start-up
  // Next helper state
  always_comb
  begin
    state_d     = state_q;
    state_d.sck = sck;
    if (state_q.up_cnt != 9'(READY_CYC))
    begin
      state_d.up_cnt = state_q.up_cnt + 9'h001;
    end
    // Straps move the clock too, but never under select
    if (sck && !state_q.sck && !ss_n)
    begin
      state_d.bits = state_q.bits + 3'h1;
    end
  end
  // Helper register
  always_ff @(posedge core_clk_in)
  begin
    if (sys_rst_in)
    begin
      state_q <= '0;
    end
    else
    begin
      state_q <= state_d;
    end
  end
  assign ready = (state_q.up_cnt == 9'(READY_CYC));
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);
  property p_startup_idle; (state_q.up_cnt < 9'(HOLD_CYC)) |-> ss_n; endproperty
  a_startup_idle: assert property (p_startup_idle) else $error("select low in start-up");
  property p_release; $rose(ss_n) |-> ##[1:8] !miso_oe; endproperty
  a_release: assert property (p_release) else $error("return line kept");
  property p_drive_sel; $rose(miso_oe) |-> !ss_n; endproperty
  a_drive_sel: assert property (p_drive_sel) else $error("drive while unselected");
  property p_answer; ready && $fell(ss_n) |-> ##[1:8] miso_oe; endproperty
  a_answer: assert property (p_answer) else $error("no return drive");
  property p_idle_low; ready && ss_n |-> !sck; endproperty
  a_idle_low: assert property (p_idle_low) else $error("clock high when idle");
  property p_half; ready && $rose(sck) |-> ##HALF_CYC $fell(sck); endproperty
  a_half: assert property (p_half) else $error("clock high time wrong");
  property p_mosi_steady; ready && sck && $past(sck) |-> $stable(mosi); endproperty
  a_mosi_steady: assert property (p_mosi_steady) else $error("host data moved");
  property p_miso_steady; ready && miso_oe && sck && $past(sck) |-> $stable(miso_drv); endproperty
  a_miso_steady: assert property (p_miso_steady) else $error("slave data moved");
  property p_whole; ready && $rose(ss_n) |-> (state_q.bits == 3'h0); endproperty
  a_whole: assert property (p_whole) else $error("partial byte in frame");
  // Main scenarios reached
  c_frame_end: cover property (ready && $rose(ss_n));
  c_slave_low: cover property (ready && !ss_n && !miso_line);
  c_byte_end: cover property (ready && !ss_n && $fell(sck) && state_q.bits == 3'h0);
endmodule

// ---- test_receiver_spi_port.sv ----
// Bench: host and receiver joined, plus a lone receiver driven by hand
`timescale 1ns/1ns
`include "spi_link_regs.svh"
module test_receiver_spi_port
  import spi_link_pkg::*;
;
  logic        clk, rst;                       // Clock and reset
  logic [1:0]  strap, cfg, cfg2;               // Straps and frozen copies
  logic        xfer_req, h_last, h_ready, h_done;
  logic [7:0]  h_tx, h_rx, r_tx, r_rx, r2_rx;  // Bytes both ways
  logic        r_valid, su_done, present, r2_valid, su2, present2;
  logic        mem_req, mem_last, sec_sel, mem_ready, mem_done, sec_sel_n, sel2_n;
  logic        mem_sck, mem_mosi, mem_sel_n, msck_q;
  logic        mem_miso = 1'h0;                // Memory stand-in data
  logic [7:0]  mem_tx, mem_rx, mem_reply;
  logic [15:0] mem_sh, mem_cap;                // Memory reply and capture
  logic [7:0]  wire_mosi, wire_miso, got_rx;   // Wire monitor bytes and last receiver byte
  logic [7:0]  rises = 8'h00, n2valid = 8'h00, mem_rises = 8'h00;
  int          num_errors = 0;
  int          checks_done = 0;
  spi_link_if link ();
  spi_link_if link2 ();   // Lone receiver, driven by hand
  spi_host_end spi_host_end_i (.core_clk_in(clk), .sys_rst_in(rst), .link(link), .strap_in(strap),
    .xfer_req_in(xfer_req), .tx_byte_in(h_tx), .last_in(h_last), .ready_out(h_ready), .rx_byte_out(h_rx),
    .done_out(h_done));
  receiver_spi_port receiver_spi_port_i (.core_clk_in(clk), .sys_rst_in(rst), .link(link), .tx_byte_in(r_tx),
    .rx_byte_out(r_rx), .rx_valid_out(r_valid), .cfg_out(cfg), .startup_done_out(su_done),
    .mem_present_out(present), .mem_req_in(mem_req), .mem_tx_in(mem_tx), .mem_last_in(mem_last),
    .second_sel_in(sec_sel), .mem_ready_out(mem_ready), .mem_rx_out(mem_rx), .mem_done_out(mem_done),
    .mem_sck_out(mem_sck), .mem_mosi_out(mem_mosi), .mem_miso_in(mem_miso), .memory_select_n(mem_sel_n),
    .second_select_n(sec_sel_n));
  // No memory here: its data line rests on the pull-up
  receiver_spi_port fault_receiver_spi_port_i (.core_clk_in(clk), .sys_rst_in(rst), .link(link2),
    .tx_byte_in(r_tx), .rx_byte_out(r2_rx), .rx_valid_out(r2_valid), .cfg_out(cfg2), .startup_done_out(su2),
    .mem_present_out(present2), .mem_req_in(mem_req), .mem_tx_in(mem_tx), .mem_last_in(mem_last),
    .second_sel_in(sec_sel), .mem_ready_out(), .mem_rx_out(), .mem_done_out(), .mem_sck_out(),
    .mem_mosi_out(), .mem_miso_in(1'h1), .memory_select_n(sel2_n), .second_select_n());
  receiver_spi_port_assertions receiver_spi_port_assertions_i (.core_clk_in(clk), .sys_rst_in(rst),
    .sck(link.sck), .ss_n(link.ss_n), .mosi(link.mosi), .miso_drv(link.miso_drv), .miso_oe(link.miso_oe),
    .miso_line(link.miso_line));
  // Core clock
  initial
  begin
    clk = 1'h0;
    forever #(`CLK_PERIOD_NS / 2) clk = ~clk;
  end
  // Wire monitor: rebuild both bytes at each clock rise under select
  always @(posedge link.sck)
  begin
    if (link.ss_n === 1'b0)
    begin
      wire_mosi <= {wire_mosi[6:0], link.mosi};
      wire_miso <= {wire_miso[6:0], link.miso_line};
      rises     <= rises + 8'h01;
    end
  end
  // Memory stand-in; unselected its line wanders so stale data never passes
  always @(posedge clk)
  begin
    msck_q <= mem_sck;
    if (r_valid === 1'b1) got_rx <= r_rx;
    if (r2_valid === 1'b1) n2valid <= n2valid + 8'h01;
    if (mem_sel_n !== 1'b0)
    begin
      mem_miso <= ~mem_miso;
      mem_sh   <= {mem_reply, `MEM_SIZE_CODE};
    end
    else
    begin
      mem_miso <= mem_sh[15];
      if (mem_sck && !msck_q) mem_cap <= {mem_cap[14:0], mem_mosi};
      if (mem_sck && !msck_q) mem_rises <= mem_rises + 8'h01;
      if (!mem_sck && msck_q) mem_sh <= {mem_sh[14:0], 1'b0};
    end
  end
  task automatic summarize();
    if (num_errors == 0 && checks_done > 0)
    begin
      $display("Run complete: PASS");
    end
    else
    begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      num_errors++;
    end
  endtask
  task automatic check_bit(input logic got, input logic exp);
    check_byte({7'h00, got}, {7'h00, exp});
  endtask
  // Bounded wait for a flag; running out ends the run
  task automatic wait_on(ref logic sig, input int limit);
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (sig !== 1'b1 && n < limit);
    if (sig !== 1'b1)
    begin
      check_bit(sig, 1'b1);
      summarize();
    end
  endtask
  // Start-up: straps frozen, memory probed
  task automatic check_startup();
    wait_on(su_done, 1000);
    check_byte(mem_cap[15:8], `MEM_PROBE_CMD);
    check_byte(mem_cap[7:0], `MEM_DUMMY);
    check_bit(present, 1'h1);
    check_byte({6'h00, cfg}, {6'h00, strap});
    wait_on(su2, 1000);
    check_bit(present2, 1'h0);
  endtask
  // One host byte; select stays low unless last
  task automatic host_byte(input logic [7:0] b, input logic last, input logic [7:0] rt);
    logic [7:0] r0;
    r0 = rises;
    wait_on(h_ready, 400);
    xfer_req <= 1'h1;
    h_tx     <= b;
    h_last   <= last;
    @(posedge clk);
    xfer_req <= 1'h0;
    wait_on(h_done, 400);
    check_byte(h_rx, rt);
    check_byte(got_rx, b);
    check_byte(wire_mosi, b);
    check_byte(wire_miso, rt);
    check_byte(rises - r0, 8'h08);
    check_bit(link.ss_n, last);
  endtask
  // Two bytes back to back in one frame
  task automatic run_frame(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] rt);
    r_tx <= rt;
    host_byte(b0, 1'h0, rt);
    host_byte(b1, 1'h1, rt);
    check_byte({6'h00, cfg}, {6'h00, strap});
  endtask
  // Memory byte; the lone receiver has no memory and must refuse
  task automatic run_memory();
    logic [7:0] m0;
    m0 = mem_rises;
    mem_reply <= 8'hc3;
    sec_sel   <= 1'h1;
    wait_on(mem_ready, 400);
    mem_req  <= 1'h1;
    mem_tx   <= 8'h96;
    mem_last <= 1'h1;
    @(posedge clk);
    mem_req <= 1'h0;
    @(posedge clk);
    check_bit(mem_sel_n, 1'h0);
    check_bit(sec_sel_n, 1'h0);
    check_bit(sel2_n, 1'h1);
    wait_on(mem_done, 200);
    check_byte(mem_rx, 8'hc3);
    check_byte(mem_cap[7:0], 8'h96);
    check_byte(mem_rises - m0, 8'h08);
    sec_sel <= 1'h0;
    repeat (3) @(posedge clk);
    check_bit(sec_sel_n, 1'h1);
    check_bit(mem_sel_n, 1'h1);
  endtask
  // One bench-made link clock, 125 ns, data set at the fall
  task automatic link_bit(input logic b);
    link2.mosi = b;
    #62;
    link2.sck = 1'h1;
    #63;
    link2.sck = 1'h0;
  endtask
  // Clocks without select, then a cut byte, then a whole one
  task automatic run_fault_end();
    logic [7:0] n0;
    n0 = n2valid;
    link2.sck = 1'h0;
    for (int i = 0; i < 16; i++) link_bit(i[0]);
    #200;
    check_byte(n2valid - n0, 8'h00);
    check_bit(link2.miso_oe, 1'h0);
    link2.ss_n = 1'h0;
    #200;
    check_bit(link2.miso_oe, 1'h1);
    for (int i = 0; i < 5; i++) link_bit(1'h1);
    link2.ss_n = 1'h1;
    #200;
    link2.ss_n = 1'h0;
    #200;
    for (int i = 7; i >= 0; i--) link_bit(8'h6c >> i);
    #200;
    link2.ss_n = 1'h1;
    repeat (10) @(posedge clk);
    check_byte(n2valid - n0, 8'h01);
    check_byte(r2_rx, 8'h6c);
    check_byte({6'h00, cfg2}, 8'h01);
  endtask
  // Main sequence
  initial
  begin
    rst        = 1'h1;
    strap      = 2'h2;
    xfer_req   = 1'h0;
    h_tx       = 8'h00;
    h_last     = 1'h0;
    r_tx       = 8'h00;
    mem_req    = 1'h0;
    mem_tx     = 8'h00;
    mem_last   = 1'h0;
    sec_sel    = 1'h0;
    mem_reply  = 8'h00;
    link2.sck  = 1'h1;
    link2.mosi = 1'h0;
    link2.ss_n = 1'h1;
    repeat (4) @(posedge clk);
    rst <= 1'h0;
    check_startup();
    run_frame(8'h00, 8'hff, 8'ha5);
    run_frame(8'h5a, 8'h81, 8'h3c);
    run_memory();
    run_fault_end();
    summarize();
  end
endmodule
